/* File: bws_bar_window_setup.sv */
// Window size and enable register bank with Avalon-MM slave
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
// What this block does
// [R1] A six-bit size field sets the window to two to the power of its value in bytes.
// [R2] Size zero means the whole addressable space; every base address bit below the addressing width is writable.
// [R3] Base address field bit zero stands for bus address bit four, upward in order.
// [R4] For size four or more, base bits inside the window read zero and ignore writes.
// [R5] A nonzero size below four makes the whole base field read-only zero.
// [R6] Software keeps memory windows at least 128 bytes and I/O windows 16 to 256 bytes.
// [R7] For I/O or 32-bit memory windows, address bits above 32 are ignored.
// [R8] The top setup bit enables the window; when clear the base register reads zero.
// [R9] Size and enable survive fundamental and hot resets and clear only on power-on reset.
// [R10] Space select picks I/O decoding when set; type code two picks 64-bit memory.
// [R11] Reserved setup bits between size and enable read zero and drop writes.
module bws_bar_window_setup
  import bws_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_fund_rst,
  input wire logic i_hot_rst,
  input wire bws_avm_req_t i_avm,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_win_active,
  output logic o_win_io,
  output logic o_win_is64,
  output logic [63:0] o_win_base,
  output logic [63:0] o_win_mask
);
  bws_state_t s_q;
  bws_state_t s_d;
  logic [59:0] wmask;
  logic [59:0] base_address_field_eff;
  logic is64;
  logic [1:0] type_eff;
  logic [31:0] setup_rd;
  logic [31:0] lo_rd;
  logic [31:0] hi_rd;
  logic unused_rst;

  // Writable base bits for a given size and addressing width
  function automatic logic [59:0] fn_wmask(input logic [5:0] size, input logic wide);
    logic [59:0] m;
    logic [6:0] a;
    m = '0;
    for (int i = 0; i < BWS_BASE_ADDRESS_FIELD_W; i++) begin
      a = 7'(i + BWS_BASE_ADDRESS_FIELD_LSB); // [R3]
      if (size == 6'h00) begin
        m[i] = 1'b1; // [R2]
      end else if (size >= BWS_SIZE_MIN && a >= {1'b0, size}) begin
        m[i] = 1'b1; // [R4]
      end else begin
        m[i] = 1'b0; // [R5]
      end
      if (!wide && a >= 7'(BWS_ADDR32_TOP)) begin
        m[i] = 1'b0; // [R7]
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] fn_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Fundamental and hot resets deliberately leave this bank alone
  assign unused_rst = i_fund_rst ^ i_hot_rst; // [R9]

  always_comb begin
    is64 = (s_q.setup.space != BWS_SPACE_IO) && (s_q.setup.addr_type == BWS_TYPE_ADDR64); // [R10]
    type_eff = (s_q.setup.space == BWS_SPACE_IO) ? 2'h0 : s_q.setup.addr_type; // [R10]
    wmask = fn_wmask(s_q.setup.size, is64);
    base_address_field_eff = s_q.base_address_field & wmask;
    setup_rd = '0; // [R11]
    setup_rd[BWS_EN_POS] = s_q.setup.en;
    setup_rd[BWS_SIZE_POS +: 6] = s_q.setup.size; // [R1]
    setup_rd[BWS_PREF_POS] = s_q.setup.pref;
    setup_rd[BWS_TYPE_POS +: 2] = type_eff;
    setup_rd[BWS_SPACE_POS] = s_q.setup.space;
    lo_rd = '0;
    hi_rd = '0;
    if (s_q.setup.en) begin
      lo_rd = {base_address_field_eff[27:0], s_q.setup.pref, type_eff, s_q.setup.space};
      hi_rd = is64 ? base_address_field_eff[59:28] : 32'h0; // [R7]
    end else begin
      lo_rd = 32'h0; // [R8]
      hi_rd = 32'h0; // [R8]
    end
  end

  always_comb begin
    logic [31:0] nw;
    nw = '0;
    s_d = s_q;
    case (s_q.st)
      BWS_IDLE: begin
        if (i_avm.read || i_avm.write) begin
          s_d.st = BWS_ACK;
          if (i_avm.read) begin
            case (i_avm.address)
              BWS_OFS_SETUP: s_d.rdata = setup_rd;
              BWS_OFS_BAR_LO: s_d.rdata = lo_rd;
              BWS_OFS_BAR_HI: s_d.rdata = hi_rd;
              default: s_d.rdata = 32'h0;
            endcase
          end
        end
      end
      BWS_ACK: begin
        s_d.st = BWS_IDLE;
        // Write lands only at the edge the master sees waitrequest low
        if (i_avm.write) begin
          case (i_avm.address)
              BWS_OFS_SETUP: begin
                nw = fn_merge(setup_rd, i_avm.writedata, i_avm.byteenable);
                s_d.setup.en = nw[BWS_EN_POS]; // [R8]
                s_d.setup.size = nw[BWS_SIZE_POS +: 6]; // [R1]
                s_d.setup.pref = nw[BWS_PREF_POS];
                s_d.setup.addr_type = nw[BWS_TYPE_POS +: 2];
                s_d.setup.space = nw[BWS_SPACE_POS];
              end
              BWS_OFS_BAR_LO: begin
                nw = fn_merge({base_address_field_eff[27:0], 4'h0}, i_avm.writedata, i_avm.byteenable);
                s_d.base_address_field[27:0] = nw[31:4] & wmask[27:0]; // [R4]
              end
              BWS_OFS_BAR_HI: begin
                nw = fn_merge(base_address_field_eff[59:28], i_avm.writedata, i_avm.byteenable);
                s_d.base_address_field[59:28] = nw & wmask[59:28]; // [R7]
              end
              default: begin
                nw = '0;
              end
            endcase
        end
      end
      default: begin
        s_d.st = BWS_IDLE;
      end
    endcase
  end

  // Only the power-on style reset clears the bank
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s_q.st <= BWS_IDLE;
      s_q.rdata <= BWS_RDATA_RST;
      s_q.setup <= BWS_SETUP_RST; // [R9]
      s_q.base_address_field <= BWS_BASE_ADDRESS_FIELD_RST;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // One wait cycle per access; a read answer leaves the register file stable, a write lands on the answer edge
  // Frozen clock enable must also stall the master, else a write would be lost
  assign o_waitrequest = (i_avm.read || i_avm.write) && (s_q.st != BWS_ACK || !i_ce);
  assign o_readdata = s_q.rdata;
  assign o_win_active = s_q.setup.en && (wmask != '0 || s_q.setup.size == 6'h00); // [R5]
  assign o_win_io = s_q.setup.space;
  assign o_win_is64 = is64;
  assign o_win_base = {base_address_field_eff, 4'h0}; // [R3]
  assign o_win_mask = {wmask, 4'h0};

  property p_rsvd_zero;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_ACK && $past(i_avm.read) && $past(i_avm.address) == BWS_OFS_SETUP)
      |-> o_readdata[30:10] == 21'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved setup bits not zero"); // [R11]

  property p_disabled_zero;
    @(posedge i_core_clk) disable iff (i_srst)
      !s_q.setup.en |-> (lo_rd == 32'h0 && hi_rd == 32'h0);
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled bar reads nonzero"); // [R8]

  property p_small_size;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.size != 6'h00 && s_q.setup.size < BWS_SIZE_MIN) |-> o_win_base == 64'h0;
  endproperty
  a_small_size: assert property (p_small_size) else $error("undersized window has base bits"); // [R5]

  property p_size0_full;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.size == 6'h00 && is64) |-> wmask == {60{1'b1}};
  endproperty
  a_size0_full: assert property (p_size0_full) else $error("size zero not fully writable"); // [R2]

  property p_inside_zero;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.size >= BWS_SIZE_MIN) |-> ((o_win_base & ((64'h1 << s_q.setup.size) - 64'h1))
                                            == 64'h0);
  endproperty
  a_inside_zero: assert property (p_inside_zero) else $error("bits inside window not zero"); // [R4]

  property p_size_bit;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.size >= BWS_SIZE_MIN && {1'b0, s_q.setup.size} < 7'(BWS_ADDR32_TOP))
      |-> o_win_mask[s_q.setup.size] && !o_win_mask[s_q.setup.size - 6'h1];
  endproperty
  a_size_bit: assert property (p_size_bit) else $error("window size boundary wrong"); // [R1]

  property p_trunc32;
    @(posedge i_core_clk) disable iff (i_srst)
      !is64 |-> o_win_base[63:32] == 32'h0 && o_win_mask[63:32] == 32'h0;
  endproperty
  a_trunc32: assert property (p_trunc32) else $error("32-bit window uses upper bits"); // [R7]

  property p_is64;
    @(posedge i_core_clk) disable iff (i_srst)
      o_win_is64 |-> (!o_win_io && s_q.setup.addr_type == BWS_TYPE_ADDR64);
  endproperty
  a_is64: assert property (p_is64) else $error("64-bit decode without type code"); // [R10]

  property p_keep_hot;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_fund_rst || i_hot_rst) && !(i_avm.write && s_q.st == BWS_ACK)
      |=> $stable(s_q.setup);
  endproperty
  a_keep_hot: assert property (p_keep_hot) else $error("setup lost on hot reset"); // [R9]

  property p_wait_bound;
    @(posedge i_core_clk) disable iff (i_srst)
      (o_waitrequest && i_ce) |=> (!o_waitrequest || !i_ce);
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("waitrequest held too long");

  property p_wait_first;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_IDLE && (i_avm.read || i_avm.write)) |-> o_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("request answered without wait");

  property p_ack_low;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_ACK && i_ce && (i_avm.read || i_avm.write)) |-> !o_waitrequest;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("waitrequest high in answer cycle");

  property p_ce_freeze;
    @(posedge i_core_clk) disable iff (i_srst)
      !i_ce |=> $stable(s_q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  property p_rdata_hold;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_ACK || !i_avm.read || !i_ce) |=> $stable(o_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed untaken");

  property p_setup_size_wr;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_ACK && i_ce && i_avm.write && i_avm.address == BWS_OFS_SETUP &&
       i_avm.byteenable == 4'hF) |=> s_q.setup.size == $past(i_avm.writedata[9:4]);
  endproperty
  a_setup_size_wr: assert property (p_setup_size_wr) else $error("size write lost"); // [R1]

  property p_setup_en_wr;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.st == BWS_ACK && i_ce && i_avm.write && i_avm.address == BWS_OFS_SETUP &&
       i_avm.byteenable == 4'hF) |=> s_q.setup.en == $past(i_avm.writedata[31]);
  endproperty
  a_setup_en_wr: assert property (p_setup_en_wr) else $error("enable write lost"); // [R8]

  property p_io_type;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.space == BWS_SPACE_IO) |-> setup_rd[2:1] == 2'h0;
  endproperty
  a_io_type: assert property (p_io_type) else $error("io window reports a type"); // [R10]

  property p_lo_nibble;
    @(posedge i_core_clk) disable iff (i_srst)
      s_q.setup.en |-> lo_rd[3:0] == {s_q.setup.pref, type_eff, s_q.setup.space};
  endproperty
  a_lo_nibble: assert property (p_lo_nibble) else $error("bar low nibble wrong"); // [R10]

  property p_hi_zero32;
    @(posedge i_core_clk) disable iff (i_srst)
      !is64 |-> hi_rd == 32'h0;
  endproperty
  a_hi_zero32: assert property (p_hi_zero32) else $error("32-bit window high half set"); // [R7]

  property p_small_off;
    @(posedge i_core_clk) disable iff (i_srst)
      (s_q.setup.size != 6'h00 && s_q.setup.size < BWS_SIZE_MIN) |-> !o_win_active;
  endproperty
  a_small_off: assert property (p_small_off) else $error("undersized window active"); // [R5]

  property p_base_nibble;
    @(posedge i_core_clk) disable iff (i_srst)
      o_win_base[3:0] == 4'h0 && o_win_mask[3:0] == 4'h0;
  endproperty
  a_base_nibble: assert property (p_base_nibble) else $error("base below bit four set"); // [R3]
endmodule
`default_nettype wire

/* File: bws_pkg.sv */
// Package for the base address window setup register bank
`default_nettype none
package bws_pkg;
  localparam logic [7:0] BWS_OFS_SETUP = 8'h00;
  localparam logic [7:0] BWS_OFS_BAR_LO = 8'h04;
  localparam logic [7:0] BWS_OFS_BAR_HI = 8'h08;
  localparam int BWS_SPACE_POS = 0;
  localparam int BWS_TYPE_POS = 1;
  localparam int BWS_PREF_POS = 3;
  localparam int BWS_SIZE_POS = 4;
  localparam int BWS_EN_POS = 31;
  localparam int BWS_BASE_ADDRESS_FIELD_LSB = 4;
  localparam int BWS_BASE_ADDRESS_FIELD_W = 60;
  localparam logic [5:0] BWS_SIZE_MIN = 6'h04;
  localparam logic [5:0] BWS_SIZE_RST = 6'h00;
  localparam logic [1:0] BWS_TYPE_ADDR64 = 2'h2;
  localparam logic [1:0] BWS_TYPE_RST = 2'h0;
  localparam logic BWS_SPACE_IO = 1'b1;
  localparam int BWS_ADDR32_TOP = 32;
  localparam logic [59:0] BWS_BASE_ADDRESS_FIELD_RST = 60'h0;
  localparam logic [31:0] BWS_RDATA_RST = 32'h0;

  typedef enum logic [1:0] {
    BWS_IDLE = 2'b00,
    BWS_ACK = 2'b01
  } bws_bus_st_t;

  typedef struct packed {
    logic en;
    logic [5:0] size;
    logic pref;
    logic [1:0] addr_type;
    logic space;
  } bws_setup_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bws_avm_req_t;

  typedef struct packed {
    bws_bus_st_t st;
    logic [31:0] rdata;
    bws_setup_t setup;
    logic [59:0] base_address_field;
  } bws_state_t;

  localparam bws_setup_t BWS_SETUP_RST = '{en: 1'b0, size: BWS_SIZE_RST, pref: 1'b0,
                                           addr_type: BWS_TYPE_RST, space: 1'b0};
endpackage
`default_nettype wire

/* File: bws_testbench.sv */
// Self-checking bench for the window size and enable register bank
`default_nettype none
module testbench
  import bws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic fund = 1'b0;
  logic hot = 1'b0;
  logic ce = 1'b1;
  bws_avm_req_t avm = '0;
  logic [31:0] rdata;
  logic wreq;
  logic act;
  logic wio;
  logic w64;
  logic [63:0] wbase;
  logic [63:0] wmask;
  logic [31:0] r;
  int mismatches = 0;
  int total_checks = 0;

  bws_bar_window_setup u_bws_bar_window_setup (.i_core_clk(clk), .i_srst(srst), .i_ce(ce),
    .i_fund_rst(fund), .i_hot_rst(hot), .i_avm(avm), .o_readdata(rdata), .o_waitrequest(wreq),
    .o_win_active(act), .o_win_io(wio), .o_win_is64(w64), .o_win_base(wbase),
    .o_win_mask(wmask));

  always #12.5 clk = ~clk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waitrequest and read data read at the edge itself, before the design updates
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avm <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    @(posedge clk);
    while (wreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) begin
      chk("waitrequest", 64'(wreq), 64'H0);
    end
    r = rdata;
    avm <= '0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    acc(1'b0, a, 32'H0);
    chk(name, 64'(r), 64'(exp));
  endtask

  task automatic t_reset();
    rd(8'H00, 32'H0, "setup");
    rd(8'H04, 32'H0, "bar_lo");
    rd(8'H08, 32'H0, "bar_hi");
    rd(8'H0C, 32'H0, "unmapped");
    chk("active", 64'(act), 64'H0);
  endtask

  task automatic t_size();
    acc(1'b1, 8'H00, 32'HFFFF_FC80);
    rd(8'H00, 32'H8000_0080, "setup");
    acc(1'b1, 8'H04, 32'HFFFF_FFFF);
    rd(8'H04, 32'HFFFF_FF00, "bar_lo");
    chk("mask", wmask, 64'H0000_0000_FFFF_FF00);
    chk("base", wbase, 64'H0000_0000_FFFF_FF00);
    chk("active", 64'(act), 64'H1);
    // Size four I/O is the smallest live window; masked bits were dropped, so rewrite
    acc(1'b1, 8'H00, 32'H8000_0041);
    acc(1'b1, 8'H04, 32'HFFFF_FFFF);
    rd(8'H04, 32'HFFFF_FFF1, "bar_lo");
    acc(1'b1, 8'H00, 32'H8000_0030);
    rd(8'H04, 32'H0, "bar_lo");
    chk("active", 64'(act), 64'H0);
  endtask

  task automatic t_full64();
    acc(1'b1, 8'H00, 32'H8000_0004);
    acc(1'b1, 8'H04, 32'HFFFF_FFFF);
    acc(1'b1, 8'H08, 32'HFFFF_FFFF);
    rd(8'H04, 32'HFFFF_FFF4, "bar_lo");
    rd(8'H08, 32'HFFFF_FFFF, "bar_hi");
    chk("is64", 64'(w64), 64'H1);
    chk("mask", wmask, 64'HFFFF_FFFF_FFFF_FFF0);
    acc(1'b1, 8'H00, 32'H0000_0004);
    rd(8'H04, 32'H0, "bar_lo");
    rd(8'H08, 32'H0, "bar_hi");
    acc(1'b1, 8'H00, 32'H8000_0004);
    rd(8'H08, 32'HFFFF_FFFF, "bar_hi");
  endtask

  task automatic t_trunc_io();
    // Size above 32 in 32-bit memory mode drops the upper bits
    acc(1'b1, 8'H00, 32'H8000_0280);
    rd(8'H08, 32'H0, "bar_hi");
    chk("is64", 64'(w64), 64'H0);
    chk("mask", wmask, 64'H0);
    acc(1'b1, 8'H00, 32'H8000_0045);
    rd(8'H00, 32'H8000_0041, "setup");
    chk("io", 64'(wio), 64'H1);
    chk("is64", 64'(w64), 64'H0);
  endtask

  task automatic t_resets();
    fund <= 1'b1;
    hot <= 1'b1;
    repeat (4) @(posedge clk);
    fund <= 1'b0;
    hot <= 1'b0;
    @(posedge clk);
    rd(8'H00, 32'H8000_0041, "setup");
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'H00, 32'H0, "setup");
  endtask

  // Clock enable held low for three edges during a write
  task automatic t_ce();
    fork
      acc(1'b1, 8'H00, 32'H8000_0070);
      begin
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk("wait_frozen", 64'(wreq), 64'H1);
        ce <= 1'b1;
      end
    join
    rd(8'H00, 32'H8000_0070, "setup");
    chk("mask", wmask, 64'H0000_0000_FFFF_FF80);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_size();
    t_full64();
    t_trunc_io();
    t_resets();
    t_ce();
    end_sim();
  end

  // Whole run is just over a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
